// file: rtl/dvol_pkg.sv
// shared constants of the digital volume stage: register map, field
// positions, reset values, gain codes, timing counts and mode codes.
// assumes nothing of its surroundings.
package dvol_pkg;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_REC_L = 8'h04;
    localparam logic [7:0] OFS_REC_R = 8'h08;
    localparam logic [7:0] OFS_PLAY_L = 8'h0C;
    localparam logic [7:0] OFS_PLAY_R = 8'h10;
    localparam logic [7:0] OFS_LIVE = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ----------------------------------------------------------------
    // control field positions and reset values
    // ----------------------------------------------------------------
    localparam int BIT_REC_AGC = 0;
    localparam int BIT_PLAY_AGC = 1;
    localparam int BIT_ADC_L = 2;
    localparam int BIT_ADC_R = 3;
    localparam int BIT_FPS = 4;
    localparam int BIT_LINK = 5;
    localparam int POS_TMO = 6;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] TMO_RST = 2'h0;

    // ----------------------------------------------------------------
    // gain codes, 0.375 dB per step
    // ----------------------------------------------------------------
    localparam logic [7:0] GAIN_MUTE = 8'h00;
    localparam logic [7:0] GAIN_0DB = 8'h91;
    localparam logic [7:0] GAIN_MAX = 8'hF1;
    localparam logic [7:0] REC_GAIN_RST = 8'hE1;
    localparam logic [7:0] PLAY_GAIN_RST = 8'h91;
    // 2^(k/16) scaled by 32768, one entry per step within 6 dB
    localparam logic [15:0] MANT [0:15] = '{
        16'h8000, 16'h85AB, 16'h8B96, 16'h91C4,
        16'h9838, 16'h9EF5, 16'hA5FF, 16'hAD58,
        16'hB505, 16'hBD09, 16'hC567, 16'hCE25,
        16'hD745, 16'hE0CD, 16'hEAC1, 16'hF525};

    // ----------------------------------------------------------------
    // timing counts
    // ----------------------------------------------------------------
    localparam logic [10:0] TMO_BASE_SAMPLES = 11'd128;
    localparam int ADC_INIT_CYCLES = 1024;

    typedef enum logic [2:0] {
        DVOL_M_REC = 3'b001,
        DVOL_M_PLAY = 3'b010,
        DVOL_M_HOLD = 3'b100
    } dvol_mode_t;

endpackage : dvol_pkg

// file: rtl/dvol_fifo.sv
// sample buffer of the volume stage: first-in first-out store with
// valid/ready on both sides.
// assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module dvol_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // full when pointers differ only in the wrap bit
    assign in_ready = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                        (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign out_data = mem[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push)
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end

endmodule : dvol_fifo

// file: rtl/dvol_chan.sv
// one channel of the volume stage: holds the applied gain, moves it to
// the target at a zero crossing or timeout, and scales samples.
// assumes smp_en pulses once per sample period on the same clock.
`timescale 1ns/1ps
module dvol_chan (
    input wire logic clk,
    input wire logic rst,
    input wire logic smp_en,
    input wire logic [15:0] smp_in,
    input wire logic [7:0] tgt_gain,
    input wire logic [1:0] tmo_sel,
    input wire logic restart,
    input wire logic force_load,
    input wire logic [7:0] gain_rst,
    output logic [7:0] gain_ff,
    output logic [15:0] smp_out_ff
);
    logic [10:0] cnt_ff;
    logic sign_ff;

    // ----------------------------------------------------------------
    // gain update timing
    // ----------------------------------------------------------------
    wire [10:0] lim_m1 = (dvol_pkg::TMO_BASE_SAMPLES << tmo_sel) - 11'd1;
    wire pending = (tgt_gain != gain_ff);
    wire zc = smp_en && (smp_in[15] != sign_ff);
    wire tmo = smp_en && (cnt_ff >= lim_m1);
    wire apply = force_load || (pending && (zc || tmo));

    // ----------------------------------------------------------------
    // scaling: mantissa from the low four bits, shift from the rest
    // ----------------------------------------------------------------
    wire [8:0] off = {1'b0, gain_ff} - 9'd145;
    wire [4:0] sh5 = off[8:4] + 5'd9;
    wire [15:0] mant = dvol_pkg::MANT[off[3:0]];
    wire signed [32:0] prod = $signed(smp_in) * $signed({1'b0, mant});
    wire signed [47:0] wide = 48'(prod) <<< sh5[3:0];
    wire fits = (&wide[47:39]) || !(|wide[47:39]);
    wire [15:0] sat = wide[47] ? 16'h8000 : 16'h7FFF;
    wire [15:0] scaled = (gain_ff == dvol_pkg::GAIN_MUTE) ? 16'h0000 :
                         (fits ? wide[39:24] : sat);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gain_ff <= dvol_pkg::GAIN_MUTE;
            cnt_ff <= 11'h000;
            sign_ff <= 1'b0;
            smp_out_ff <= 16'h0000;
        end else begin
            if (apply)
                gain_ff <= tgt_gain;
            if (restart || apply)
                cnt_ff <= 11'h000;
            else if (smp_en && cnt_ff != 11'h7FF)
                cnt_ff <= cnt_ff + 11'd1;
            if (smp_en) begin
                sign_ff <= smp_in[15];
                smp_out_ff <= scaled;
            end
        end
    end

    // gain_rst is the reset face value, checked on the edge after reset
    property p_reset_gain;
        @(posedge clk)
        $fell(rst) |-> gain_ff == gain_rst;
    endproperty
    a_reset_gain: assert property (p_reset_gain)
        else $error("applied gain not at reset value");

    property p_zc_apply;
        @(posedge clk) disable iff (rst)
        zc && pending |=> gain_ff == $past(tgt_gain);
    endproperty
    a_zc_apply: assert property (p_zc_apply)
        else $error("gain not applied at zero crossing");

    property p_tmo_apply;
        @(posedge clk) disable iff (rst)
        smp_en && pending && cnt_ff >= lim_m1 |=> gain_ff == $past(tgt_gain);
    endproperty
    a_tmo_apply: assert property (p_tmo_apply)
        else $error("gain not applied at timeout");

    property p_restart;
        @(posedge clk) disable iff (rst)
        restart |=> cnt_ff == 11'h000;
    endproperty
    a_restart: assert property (p_restart)
        else $error("write did not restart counter");

    property p_mute;
        @(posedge clk) disable iff (rst)
        smp_en && gain_ff == dvol_pkg::GAIN_MUTE |=> smp_out_ff == 16'h0000;
    endproperty
    a_mute: assert property (p_mute)
        else $error("mute code passed signal");

    property p_unity;
        @(posedge clk) disable iff (rst)
        smp_en && gain_ff == dvol_pkg::GAIN_0DB |=>
            smp_out_ff == $past(smp_in);
    endproperty
    a_unity: assert property (p_unity)
        else $error("0 dB code changed sample");

endmodule : dvol_chan

// file: rtl/dvol_top.sv
// manual digital volume stage of a stereo codec: register port, mode
// selection, sample buffer and two gain channels.
// assumes samples arrive on the register clock as left/right pairs.
//
// How it works
// - live applied left-channel gain readable at any time
// - gain code 0.375 dB steps, 91H unity
// - record manual mode: agc off, adc on, path 0
// - record gains default E1H, 00H mutes
// - record gain applied at crossing or timeout
// - record gains written powered down apply after init
// - playback manual: agc off, adc off or path 1
// - playback gains default 91H, 0H mutes
// - link bit makes left gain drive both
// - playback gain applied at crossing or timeout
// - changed gain write restarts the timeout counter
// - rewriting the same gain restarts nothing
// - timeout 128, 256, 512, 1024 samples
`timescale 1ns/1ps
module dvol_top #(
    parameter int FIFO_DEPTH = 16,
    parameter int ADC_INIT_CYCLES = dvol_pkg::ADC_INIT_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic S_IN_VALID,
    output logic S_IN_READY,
    input wire logic [15:0] S_IN_LEFT,
    input wire logic [15:0] S_IN_RIGHT,
    output logic S_OUT_VALID,
    input wire logic S_OUT_READY,
    output logic [15:0] S_OUT_LEFT,
    output logic [15:0] S_OUT_RIGHT
);
    initial begin
        if (ADC_INIT_CYCLES < 1 || ADC_INIT_CYCLES > 65535)
            $error("adc init count out of range");
    end

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [7:0] rec_l_ff;
    logic [7:0] rec_r_ff;
    logic [7:0] play_l_ff;
    logic [7:0] play_r_ff;
    logic [31:0] rdata_ff;

    wire wr_ctrl = WR && (ADDR == dvol_pkg::OFS_CTRL);
    wire wr_rec_l = WR && (ADDR == dvol_pkg::OFS_REC_L);
    wire wr_rec_r = WR && (ADDR == dvol_pkg::OFS_REC_R);
    wire wr_play_l = WR && (ADDR == dvol_pkg::OFS_PLAY_L);
    wire wr_play_r = WR && (ADDR == dvol_pkg::OFS_PLAY_R);

    wire rec_agc_enable = ctrl_ff[dvol_pkg::BIT_REC_AGC];
    wire play_agc_enable = ctrl_ff[dvol_pkg::BIT_PLAY_AGC];
    wire adc_left_power = ctrl_ff[dvol_pkg::BIT_ADC_L];
    wire adc_right_power = ctrl_ff[dvol_pkg::BIT_ADC_R];
    wire filter_path_select = ctrl_ff[dvol_pkg::BIT_FPS];
    wire play_gain_link = ctrl_ff[dvol_pkg::BIT_LINK];
    wire [1:0] zero_cross_timeout_sel =
        ctrl_ff[dvol_pkg::POS_TMO +: 2];

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ctrl_ff <= dvol_pkg::CTRL_RST;
            rec_l_ff <= dvol_pkg::REC_GAIN_RST;
            rec_r_ff <= dvol_pkg::REC_GAIN_RST;
            play_l_ff <= dvol_pkg::PLAY_GAIN_RST;
            play_r_ff <= dvol_pkg::PLAY_GAIN_RST;
        end else begin
            if (wr_ctrl)
                ctrl_ff <= WDATA[7:0];
            if (wr_rec_l)
                rec_l_ff <= WDATA[7:0];
            if (wr_rec_r)
                rec_r_ff <= WDATA[7:0];
            if (wr_play_l)
                play_l_ff <= WDATA[7:0];
            if (wr_play_r)
                play_r_ff <= WDATA[7:0];
        end
    end

    // ----------------------------------------------------------------
    // mode selection
    // ----------------------------------------------------------------
    wire adc_on = adc_left_power || adc_right_power;
    wire rec_manual = !rec_agc_enable && adc_on && !filter_path_select;
    wire play_manual = !play_agc_enable &&
                       (!adc_on || filter_path_select);
    dvol_pkg::dvol_mode_t mode;

    // a path under level control keeps its last gain; the limiter and
    // recovery machinery is outside this stage
    assign mode = rec_manual ? dvol_pkg::DVOL_M_REC :
                  play_manual ? dvol_pkg::DVOL_M_PLAY :
                  dvol_pkg::DVOL_M_HOLD;

    // ----------------------------------------------------------------
    // adc initialisation after power-up
    // ----------------------------------------------------------------
    logic adc_on_ff;
    logic [15:0] init_cnt_ff;
    wire adc_rise = adc_on && !adc_on_ff;
    wire init_busy = (init_cnt_ff != 16'h0000);
    wire init_done = (init_cnt_ff == 16'h0001);

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            adc_on_ff <= 1'b0;
            init_cnt_ff <= 16'h0000;
        end else begin
            adc_on_ff <= adc_on;
            if (!adc_on)
                init_cnt_ff <= 16'h0000;
            else if (adc_rise)
                init_cnt_ff <= 16'(ADC_INIT_CYCLES);
            else if (init_busy)
                init_cnt_ff <= init_cnt_ff - 16'd1;
        end
    end

    // held record gains land all at once when initialisation ends
    wire force_rec = init_done && (mode == dvol_pkg::DVOL_M_REC);
    // the last init cycle must not freeze, or the forced load would
    // reload the old gain instead of the held register value
    wire frozen = (adc_rise || (init_busy && !init_done)) &&
                  (mode == dvol_pkg::DVOL_M_REC);

    // ----------------------------------------------------------------
    // gain targets and counter restarts
    // ----------------------------------------------------------------
    logic [7:0] gain_l;
    logic [7:0] gain_r;
    logic [7:0] tgt_l;
    logic [7:0] tgt_r;
    logic restart_l;
    logic restart_r;

    wire [7:0] play_tgt_r = play_gain_link ? play_l_ff : play_r_ff;
    wire new_play_l = wr_play_l && (WDATA[7:0] != play_l_ff);
    wire new_play_r = wr_play_r && (WDATA[7:0] != play_r_ff);
    wire new_rec_l = wr_rec_l && (WDATA[7:0] != rec_l_ff);
    wire new_rec_r = wr_rec_r && (WDATA[7:0] != rec_r_ff);

    always_comb begin
        tgt_l = gain_l;
        tgt_r = gain_r;
        restart_l = 1'b0;
        restart_r = 1'b0;
        unique case (mode)
            dvol_pkg::DVOL_M_REC: begin
                if (!frozen) begin
                    tgt_l = rec_l_ff;
                    tgt_r = rec_r_ff;
                end
                restart_l = new_rec_l;
                restart_r = new_rec_r;
            end
            dvol_pkg::DVOL_M_PLAY: begin
                tgt_l = play_l_ff;
                tgt_r = play_tgt_r;
                restart_l = new_play_l;
                restart_r = play_gain_link ? new_play_l : new_play_r;
            end
            dvol_pkg::DVOL_M_HOLD: begin
                tgt_l = gain_l;
                tgt_r = gain_r;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sample path: buffer, gain channels, output register
    // ----------------------------------------------------------------
    logic fifo_valid;
    logic [31:0] fifo_data;
    logic out_valid_ff;
    wire smp_en = fifo_valid && (!out_valid_ff || S_OUT_READY);

    dvol_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(REF_CLK),
        .rst(RST),
        .in_valid(S_IN_VALID),
        .in_ready(S_IN_READY),
        .in_data({S_IN_LEFT, S_IN_RIGHT}),
        .out_valid(fifo_valid),
        .out_ready(smp_en),
        .out_data(fifo_data)
    );

    dvol_chan u_chan_l (
        .clk(REF_CLK),
        .rst(RST),
        .smp_en(smp_en),
        .smp_in(fifo_data[31:16]),
        .tgt_gain(tgt_l),
        .tmo_sel(zero_cross_timeout_sel),
        .restart(restart_l),
        .force_load(force_rec),
        .gain_rst(dvol_pkg::GAIN_MUTE),
        .gain_ff(gain_l),
        .smp_out_ff(S_OUT_LEFT)
    );

    dvol_chan u_chan_r (
        .clk(REF_CLK),
        .rst(RST),
        .smp_en(smp_en),
        .smp_in(fifo_data[15:0]),
        .tgt_gain(tgt_r),
        .tmo_sel(zero_cross_timeout_sel),
        .restart(restart_r),
        .force_load(force_rec),
        .gain_rst(dvol_pkg::GAIN_MUTE),
        .gain_ff(gain_r),
        .smp_out_ff(S_OUT_RIGHT)
    );

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST)
            out_valid_ff <= 1'b0;
        else if (smp_en)
            out_valid_ff <= 1'b1;
        else if (S_OUT_READY)
            out_valid_ff <= 1'b0;
    end
    assign S_OUT_VALID = out_valid_ff;

    // ----------------------------------------------------------------
    // read port: data stands in the cycle after the strobe only
    // ----------------------------------------------------------------
    wire [7:0] status = {3'b000, init_busy, adc_on, mode};
    wire [7:0] rd_mux =
        (ADDR == dvol_pkg::OFS_CTRL) ? ctrl_ff :
        (ADDR == dvol_pkg::OFS_REC_L) ? rec_l_ff :
        (ADDR == dvol_pkg::OFS_REC_R) ? rec_r_ff :
        (ADDR == dvol_pkg::OFS_PLAY_L) ? play_l_ff :
        (ADDR == dvol_pkg::OFS_PLAY_R) ? play_r_ff :
        (ADDR == dvol_pkg::OFS_LIVE) ? gain_l :
        (ADDR == dvol_pkg::OFS_STATUS) ? status : 8'h00;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST)
            rdata_ff <= 32'h00000000;
        else if (RD)
            rdata_ff <= {24'h000000, rd_mux};
        else
            rdata_ff <= 32'h00000000;
    end
    assign RDATA = rdata_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_live_read;
        @(posedge REF_CLK) disable iff (RST)
        RD && ADDR == dvol_pkg::OFS_LIVE |=>
            RDATA == {24'h000000, $past(gain_l)};
    endproperty
    a_live_read: assert property (p_live_read)
        else $error("live gain readback wrong");

    property p_rec_mode;
        @(posedge REF_CLK) disable iff (RST)
        !rec_agc_enable && adc_on && !filter_path_select |->
            mode == dvol_pkg::DVOL_M_REC;
    endproperty
    a_rec_mode: assert property (p_rec_mode)
        else $error("record manual mode not selected");

    property p_play_mode;
        @(posedge REF_CLK) disable iff (RST)
        !play_agc_enable && (!adc_on || filter_path_select) |->
            mode != dvol_pkg::DVOL_M_HOLD;
    endproperty
    a_play_mode: assert property (p_play_mode)
        else $error("playback manual mode not selected");

    property p_link;
        @(posedge REF_CLK) disable iff (RST)
        mode == dvol_pkg::DVOL_M_PLAY && play_gain_link |->
            tgt_r == play_l_ff && restart_r == restart_l;
    endproperty
    a_link: assert property (p_link)
        else $error("linked right gain not following left");

    property p_same_write;
        @(posedge REF_CLK) disable iff (RST)
        wr_play_l && WDATA[7:0] == play_l_ff |-> !restart_l;
    endproperty
    a_same_write: assert property (p_same_write)
        else $error("same-value write restarted counter");

    property p_init_load;
        @(posedge REF_CLK) disable iff (RST)
        force_rec |=> gain_l == $past(rec_l_ff) && gain_r == $past(rec_r_ff);
    endproperty
    a_init_load: assert property (p_init_load)
        else $error("held record gain not applied after init");

    property p_init_hold;
        @(posedge REF_CLK) disable iff (RST)
        frozen && !force_rec |=> $stable(gain_l);
    endproperty
    a_init_hold: assert property (p_init_hold)
        else $error("record gain moved during adc init");

    property p_rd_pulse;
        @(posedge REF_CLK) disable iff (RST)
        !RD |=> RDATA == 32'h00000000;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read data stood past its cycle");

endmodule : dvol_top

// file: verif/dvol_top_test.sv
// self-checking bench of the manual digital volume stage.
// assumes the design files and dvol_pkg are compiled first.
`timescale 1ns/1ps
module dvol_top_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic iv = 1'b0;
    logic irdy;
    logic [15:0] il = 16'h0;
    logic [15:0] ir = 16'h0;
    logic ov;
    logic ordy = 1'b1;
    logic [15:0] ol;
    logic [15:0] orr;
    logic [15:0] ql [$];
    logic [15:0] qr [$];
    int failures = 0;
    int n_compared = 0;
    int n;
    logic [31:0] q;
    logic [7:0] g;
    logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
        8'h18, 8'h1C, 8'hFC};
    logic [7:0] re [9] = '{8'h00, 8'hE1, 8'hE1, 8'h91, 8'h91, 8'h00,
        8'h02, 8'h00, 8'h00};
    logic [7:0] mc [6] = '{8'h04, 8'h08, 8'h14, 8'h05, 8'h02, 8'h00};
    dvol_pkg::dvol_mode_t me [6] = '{dvol_pkg::DVOL_M_REC,
        dvol_pkg::DVOL_M_REC, dvol_pkg::DVOL_M_PLAY, dvol_pkg::DVOL_M_HOLD,
        dvol_pkg::DVOL_M_HOLD, dvol_pkg::DVOL_M_PLAY};

    // short init count keeps the power-up wait to a few cycles
    dvol_top #(.FIFO_DEPTH(16), .ADC_INIT_CYCLES(4)) DUT (
        .REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .S_IN_VALID(iv), .S_IN_READY(irdy),
        .S_IN_LEFT(il), .S_IN_RIGHT(ir), .S_OUT_VALID(ov),
        .S_OUT_READY(ordy), .S_OUT_LEFT(ol), .S_OUT_RIGHT(orr));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (ov && ordy) begin
            ql.push_back(ol);
            qr.push_back(orr);
        end
    end

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, {24'h0, e});
    endtask : rc

    task automatic live(input logic [7:0] e);
        rc(dvol_pkg::OFS_LIVE, e);
    endtask : live

    task automatic run(input int k, input logic [15:0] l,
                       input logic [15:0] r);
        logic ok;
        for (int i = 0; i < k; i++) begin
            n = 0;
            @(posedge clk);
            iv <= 1'b1;
            il <= l;
            ir <= r;
            do begin
                @(negedge clk);
                ok = irdy;
                @(posedge clk);
                n++;
            end while (!ok && n < 50);
            if (!ok)
                chk(ok, 1'b1);
            iv <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask : run

    // a positive then a negative pair crosses zero on both channels
    task automatic xing();
        run(1, 16'h0100, 16'h0100);
        run(1, 16'hFF00, 16'hFF00);
    endtask : xing

    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        #400us;
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wr_reg(8'h1C, 8'hFF);
        wr_reg(dvol_pkg::OFS_LIVE, 8'h55);
        for (int i = 0; i < 9; i++) begin
            rc(ra[i], re[i]);
        end
        $display("test reset done");
        xing();
        live(dvol_pkg::GAIN_0DB);
        run(2, 16'h1234, 16'h0567);
        chk({16'h0, ql[$]}, 32'h1234);
        $display("test crossing done");
        for (int c = 0; c < 4; c++) begin
            wr_reg(dvol_pkg::OFS_CTRL, {c[1:0], 6'h00});
            g = c[0] ? 8'h91 : 8'h80;
            wr_reg(dvol_pkg::OFS_PLAY_L, g);
            run((128 << c) - 8, 16'h0100, 16'h0100);
            live(c[0] ? 8'h80 : 8'h91);
            run(16, 16'h0100, 16'h0100);
            live(g);
        end
        $display("test timeout done");
        wr_reg(dvol_pkg::OFS_CTRL, 8'h00);
        // changed values every 64 samples keep the counter from expiring
        for (int i = 0; i < 6; i++) begin
            wr_reg(dvol_pkg::OFS_PLAY_L, i[0] ? 8'h71 : 8'h70);
            run(64, 16'h0100, 16'h0100);
        end
        live(8'h91);
        for (int i = 0; i < 4; i++) begin
            wr_reg(dvol_pkg::OFS_PLAY_L, 8'h85);
            run(64, 16'h0100, 16'h0100);
        end
        live(8'h85);
        $display("test restart done");
        wr_reg(dvol_pkg::OFS_PLAY_L, 8'h91);
        wr_reg(dvol_pkg::OFS_CTRL, 8'h20);
        wr_reg(dvol_pkg::OFS_PLAY_R, 8'h00);
        xing();
        run(2, 16'h0200, 16'h0300);
        chk({16'h0, qr[$]}, 32'h0300);
        wr_reg(dvol_pkg::OFS_CTRL, 8'h00);
        xing();
        run(2, 16'h0200, 16'h0300);
        chk({16'h0, qr[$]}, 32'h0000);
        $display("test link done");
        wr_reg(dvol_pkg::OFS_REC_L, 8'h40);
        wr_reg(dvol_pkg::OFS_CTRL, 8'h04);
        repeat (12) @(posedge clk);
        live(8'h40);
        for (int i = 0; i < 6; i++) begin
            wr_reg(dvol_pkg::OFS_CTRL, mc[i]);
            repeat (8) @(posedge clk);
            rc(dvol_pkg::OFS_STATUS,
               {4'h0, mc[i][2] | mc[i][3], me[i]});
        end
        $display("test modes done");
        // a crossing in playback mode brings the left gain back to unity
        xing();
        ql.delete();
        @(posedge clk);
        ordy <= 1'b0;
        iv <= 1'b1;
        il <= 16'h0;
        n = 0;
        repeat (40) begin
            @(negedge clk);
            if (irdy) begin
                n++;
            end
            @(posedge clk);
            il <= 16'(n);
        end
        iv <= 1'b0;
        // sixteen words in the buffer plus one in the output register
        chk(n, 17);
        ordy <= 1'b1;
        repeat (40) @(posedge clk);
        chk(ql.size(), n);
        for (int i = 0; i < ql.size(); i++) begin
            chk({16'h0, ql[i]}, i);
        end
        $display("test buffer done");
        report_and_stop();
    end
endmodule : dvol_top_test
